// ### verification/ssr_spi_master.sv
// spi master model: 160 ns serial clock, mode 0, clock still between frames
// assumes the bench calls its tasks one at a time
`timescale 1ns/10ps
module ssr_spi_master
(
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   output logic      hold_n,
   input  wire logic so,
   input  wire logic so_oe
);
   logic seen_q;
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
      seen_q = 1'b0;
   end
   // odd offset keeps the link phase unrelated to the system clock
   task frame_on;
      #13 cs_n = 1'b0;
      #40;
   endtask
   task frame_off;
      #40 cs_n = 1'b1;
      #200;
   endtask
   // an undriven output reads as the inverse of the last bit, never a lucky match
   task xbits(input logic [7:0] tx, input int nb, inout logic [7:0] rx);
      for (int j = 0; j < nb; j++)
      begin
         si = tx[7 - j];
         #40 sck = 1'b1;
         seen_q = so_oe ? so : ~seen_q;
         rx = {rx[6:0], seen_q};
         #80 sck = 1'b0;
         #20 si = ~si;
         #20;
      end
   endtask
   // pause set and cleared with the clock low, one clock edge given inside
   task pause;
      hold_n = 1'b0;
      si = ~si;
      #80 sck = 1'b1;
      #80 sck = 1'b0;
      #80 hold_n = 1'b1;
      #80;
   endtask
endmodule // ssr_spi_master

// ### verification/ssr_sram_asserts.sv
// checker of the serial sram access block, bound to its top module
// assumes mode 0 traffic, status left unchanged within a frame
`timescale 1ns/10ps
module ssr_sram_asserts
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       sck,
   input wire logic       cs_n,
   input wire logic       si,
   input wire logic       hold_n,
   input wire logic       so,
   input wire logic       so_oe,
   input wire logic [1:0] sys_mode,
   input wire logic       sys_hold_dis,
   input wire logic       sys_selected
);
   logic [5:0] cnt_q;
   logic [7:0] op_q;
   logic       act;
   logic [7:0] st_w;
   logic       burst;
   logic       arm_q;
   // nothing counts until chip select has fallen since the last reset
   always_ff @(negedge cs_n or posedge rst)
   begin
      if (rst)
         arm_q <= 1'b0;
      else
         arm_q <= 1'b1;
   end
   assign act = arm_q && (hold_n || sys_hold_dis);
   assign st_w = {sys_mode, 4'h0, 1'b1, sys_hold_dis};
   assign burst = (sys_mode == 2'h1) || (sys_mode == 2'h2);
   // edge count wraps 39 to 32 so bit position survives long bursts
   always_ff @(posedge sck or posedge cs_n or posedge rst)
      if (rst || cs_n)
      begin
         cnt_q <= 6'h00;
         op_q <= 8'h00;
      end
      else if (act)
      begin
         cnt_q <= (cnt_q == 6'h27) ? 6'h20 : cnt_q + 6'h01;
         if (cnt_q < 6'h08)
            op_q <= {op_q[6:0], si};
      end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   sequence s_low4;
      (!cs_n) [*4];
   endsequence
   property p_cs_off;
      @(posedge clk_sys) disable iff (rst) cs_n |-> !so_oe;
   endproperty
   property p_pause_off;
      @(posedge clk_sys) disable iff (rst) (!cs_n && !hold_n && !sys_hold_dis) |-> !so_oe;
   endproperty
   property p_sel;
      @(posedge clk_sys) disable iff (rst) s_low4 |-> sys_selected;
   endproperty
   property p_opc_quiet;
      @(posedge sck) disable iff (rst || cs_n) (cnt_q < 6'h08 || (op_q == 8'h03 && cnt_q < 6'h18)) |-> !so_oe;
   endproperty
   property p_no_out;
      @(posedge sck) disable iff (rst || cs_n) (cnt_q >= 6'h08 && op_q != 8'h03 && op_q != 8'h05) |-> !so_oe;
   endproperty
   property p_rd_on;
      @(posedge sck) disable iff (rst || cs_n)
         (op_q == 8'h03 && cnt_q >= 6'h18 && act && (burst || cnt_q < 6'h20)) |-> so_oe;
   endproperty
   property p_byte_stop;
      @(posedge sck) disable iff (rst || cs_n) (op_q == 8'h03 && cnt_q >= 6'h20 && !burst) |-> !so_oe;
   endproperty
   property p_st_val;
      @(posedge sck) disable iff (rst || cs_n)
         (op_q == 8'h05 && cnt_q >= 6'h08 && act) |-> (so_oe && so == st_w[~cnt_q[2:0]]);
   endproperty
   a_cs_off: assert property (p_cs_off) else $error("output enabled while deselected");
   a_pause_off: assert property (p_pause_off) else $error("output enabled while paused");
   a_sel: assert property (p_sel) else $error("selection not mirrored");
   a_opc_quiet: assert property (p_opc_quiet) else $error("output before address done");
   a_no_out: assert property (p_no_out) else $error("output on a non-read opcode");
   a_rd_on: assert property (p_rd_on) else $error("read data not driven");
   a_byte_stop: assert property (p_byte_stop) else $error("byte mode sent a second byte");
   a_st_val: assert property (p_st_val) else $error("status bit wrong");
endmodule // ssr_sram_asserts

bind ssr_sram ssr_sram_asserts chk (.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
   .hold_n(hold_n), .so(so), .so_oe(so_oe), .sys_mode(sys_mode), .sys_hold_dis(sys_hold_dis),
   .sys_selected(sys_selected));

// ### verification/ssr_sram_tb.sv
// self-checking bench of the serial sram access block
// assumes the master model and the bound checker are compiled with it
`timescale 1ns/10ps
module ssr_sram_tb;
   typedef struct packed {logic [7:0] st; logic wr; logic [15:0] a; logic [5:0] n; logic [7:0] d0;} ssr_row_s;
   logic       clk_sys, rst, sck, cs_n, si, hold_n, so, so_oe, sys_hold_dis, sys_selected;
   logic [1:0] sys_mode;
   logic [7:0] mem_r [8192];
   logic [7:0] rx;
   logic [12:0] ad;
   int         errors, checks;
   ssr_row_s   rows [7];
   ssr_sram uut (.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
      .so_oe(so_oe), .sys_mode(sys_mode), .sys_hold_dis(sys_hold_dis), .sys_selected(sys_selected));
   ssr_spi_master m (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task close_out;
      if (errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task cmd(input logic [7:0] op, input logic [15:0] a);
      m.frame_on();
      m.xbits(op, 8, rx);
      m.xbits(a[15:8], 8, rx);
      m.xbits(a[7:0], 8, rx);
      ad = a[12:0];
   endtask
   // status write, then read back twice since it repeats
   task wr_st(input logic [7:0] st);
      m.frame_on();
      m.xbits(8'h01, 8, rx);
      m.xbits(st, 8, rx);
      m.frame_off();
      m.frame_on();
      m.xbits(8'h05, 8, rx);
      repeat (2)
      begin
         m.xbits(8'h00, 8, rx);
         check("status", rx, {st[7:6], 4'h0, 1'b1, st[0]});
      end
      m.frame_off();
   endtask
   function logic [12:0] nxt(input logic [12:0] x, input logic [1:0] md);
      return (md == 2'h2) ? {x[12:5], x[4:0] + 5'h01} : x + 13'h0001;
   endfunction
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      errors = 0;
      checks = 0;
      rows = '{'{8'h00, 1'b1, 16'hE123, 6'h01, 8'h5A}, '{8'h00, 1'b0, 16'h0123, 6'h01, 8'h00},
               '{8'h80, 1'b1, 16'h005E, 6'h22, 8'h10}, '{8'h80, 1'b0, 16'h0040, 6'h21, 8'h00},
               '{8'h41, 1'b1, 16'h1FFE, 6'h04, 8'hA0}, '{8'h41, 1'b0, 16'h1FFE, 6'h04, 8'h00},
               '{8'hC0, 1'b0, 16'h0123, 6'h01, 8'h00}};
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check("oe", {7'h00, so_oe}, 8'h00);
      check("mode", {6'h00, sys_mode}, 8'h00);
      foreach (rows[i])
      begin
         wr_st(rows[i].st);
         cmd(rows[i].wr ? 8'h02 : 8'h03, rows[i].a);
         for (int k = 0; k < rows[i].n; k++)
         begin
            if (rows[i].wr)
            begin
               m.xbits(rows[i].d0 + k[7:0], 8, rx);
               mem_r[ad] = rows[i].d0 + k[7:0];
            end
            else
            begin
               m.xbits(8'h00, 8, rx);
               check("read", rx, mem_r[ad]);
            end
            ad = nxt(ad, rows[i].st[7:6]);
         end
         m.frame_off();
      end
      // unknown opcode, then a write cut after four bits
      wr_st(8'h00);
      cmd(8'hFF, 16'h0000);
      m.xbits(8'h00, 8, rx);
      check("unknown", {7'h00, so_oe}, 8'h00);
      m.frame_off();
      cmd(8'h02, 16'h0123);
      m.xbits(8'hFF, 4, rx);
      m.frame_off();
      // read paused mid byte, the clock edge inside the pause is ignored
      cmd(8'h03, 16'h0123);
      m.xbits(8'h00, 4, rx);
      m.pause();
      m.xbits(8'h00, 4, rx);
      check("pause", rx, 8'h5A);
      m.frame_off();
      // reset in mid frame: with no falling select edge since, a status read stays silent
      wr_st(8'h40);
      m.frame_on();
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #13;
      m.xbits(8'h05, 8, rx);
      m.xbits(8'h00, 8, rx);
      check("unarmed", {7'h00, so_oe}, 8'h00);
      check("mode", {6'h00, sys_mode}, 8'h00);
      m.frame_off();
      close_out();
   end
   // watchdog well beyond the roughly two hundred microseconds of traffic
   initial
   begin
      #2000000;
      errors++;
      close_out();
   end
endmodule // ssr_sram_tb

// ### verilog/ssr_map.svh
// constants of the serial sram access block: opcodes, status layout, sizes
// assumes it is included by bare name from the package and the design file
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// ---------------------------------------------------------------
// instruction codes
// ---------------------------------------------------------------
`define SSR_OP_MEM_READ      8'h03
`define SSR_OP_MEM_WRITE     8'h02
`define SSR_OP_STATUS_READ   8'h05
`define SSR_OP_STATUS_WRITE  8'h01

// ---------------------------------------------------------------
// field sizes and bit counts
// ---------------------------------------------------------------
`define SSR_ADDR_W           13
`define SSR_MEM_DEPTH        8192
`define SSR_CMD_LAST_BIT     5'h07
`define SSR_ADDR_LAST_BIT    5'h0F
`define SSR_DATA_LAST_BIT    5'h07
`define SSR_PAGE_LSB_W       5

// ---------------------------------------------------------------
// status byte layout and reset values
// ---------------------------------------------------------------
`define SSR_ST_MODE_HI       7
`define SSR_ST_MODE_LO       6
`define SSR_ST_ONE_BIT       1
`define SSR_ST_HOLD_DIS_BIT  0
`define SSR_MODE_BYTE        2'h0
`define SSR_MODE_PAGE        2'h2
`define SSR_MODE_SEQ         2'h1
`define SSR_MODE_RESET       2'h0
`define SSR_HOLD_DIS_RESET   1'h0

`endif

// ### verilog/ssr_pkg.sv
// types of the serial sram access block
// assumes ssr_map.svh is on the include path
package ssr_pkg;
   `include "ssr_map.svh"

   // phase of the serial sequence inside one chip select frame
   typedef enum logic [2:0] {
      SSR_PH_CMD,
      SSR_PH_ADDR,
      SSR_PH_DATA,
      SSR_PH_ST_RD,
      SSR_PH_ST_WR,
      SSR_PH_IDLE
   } ssr_phase_e;

   // serial sequence state, cleared whenever chip select is high
   typedef struct packed {
      ssr_phase_e              phase;
      logic [4:0]              bitcnt;
      logic [15:0]             shreg;
      logic                    is_read;
      logic [`SSR_ADDR_W-1:0]  addr;
   } ssr_seq_s;

   // status byte contents that survive between frames
   typedef struct packed {
      logic [1:0]              mode;
      logic                    hold_dis;
   } ssr_stat_s;

   // serial output stage, updated on the falling serial clock
   typedef struct packed {
      logic                    so;
      logic                    so_oe;
   } ssr_out_s;

   // system clock side mirror of the link state
   typedef struct packed {
      logic [3:0]              meta;
      logic [3:0]              sync;
   } ssr_sys_s;
endpackage

// ### verilog/ssr_sram.sv
// serial sram access logic: spi slave command decode, address pointer, 8192 byte array
// assumes the master runs spi mode 0 on sck, which stands still outside frames
`timescale 1ns/10ps

// ---------------------------------------------------------------
// shared constants
// ---------------------------------------------------------------
// the header is guarded, so including it here as well as in the
// package costs nothing and lets this file stand on its own when
// it is compiled as a separate unit
`include "ssr_map.svh"

// ---------------------------------------------------------------
// frame sequence
// ---------------------------------------------------------------
// each frame opens in the command phase and the opcode picks the next:
// address then data for the array, status read or status write for the
// status byte, idle for anything unknown; idle ignores further clocks,
// so a finished byte-mode or status-write frame stays quiet until
// chip select rises; the status byte lives in the serial clock domain
// and reaches the system side only through a two-stage mirror, which
// is good enough because it changes only between frames
//
module ssr_sram
   import ssr_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic        si,
   input  wire logic        hold_n,
   output logic             so,
   output logic             so_oe,
   output logic [1:0]       sys_mode,
   output logic             sys_hold_dis,
   output logic             sys_selected
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   ssr_seq_s                seq_q;
   ssr_seq_s                seq_d;
   ssr_stat_s               stat_q;
   ssr_stat_s               stat_d;
   ssr_out_s                out_q;
   ssr_out_s                out_d;
   ssr_sys_s                sys_q;
   ssr_sys_s                sys_d;
   logic                    armed_q;
   logic [7:0]              mem [0:`SSR_MEM_DEPTH-1];
   logic                    paused;
   logic                    seq_clr;
   logic                    out_clr;
   logic [7:0]              in_byte;
   logic [7:0]              rd_byte;
   logic [7:0]              st_byte;
   logic [`SSR_ADDR_W-1:0]  next_addr;
   logic                    mem_we;
   logic                    step;

   // ---------------------------------------------------------------
   // frame control
   // ---------------------------------------------------------------
   // pause only counts while enabled by the status byte
   // limitation: pause is taken as a level, so a master that lowers it
   // while the serial clock is high pauses at once, not at the next
   // falling edge; the master is expected to move it with the clock low
   assign paused  = ~hold_n & ~stat_q.hold_dis;
   // chip select high abandons any sequence without needing a clock edge
   // and also covers a master that stops the clock in mid byte
   assign seq_clr = rst | cs_n;
   assign out_clr = rst | cs_n;
   // a rising edge counts only when selected, armed and not paused
   assign step    = armed_q & ~cs_n & ~paused;

   // a falling chip select edge must be seen after reset before commands run
   // a flop of its own, since chip select high clears the whole sequence
   always_ff @(negedge cs_n or posedge rst)
   begin
      if (rst)
         armed_q <= 1'b0;
      else
         armed_q <= 1'b1;
   end

   // ---------------------------------------------------------------
   // serial sequence, rising serial clock
   // ---------------------------------------------------------------
   // byte views of the shift register, the array and the status byte
   assign in_byte = {seq_q.shreg[6:0], si};
   assign rd_byte = mem[seq_q.addr];
   assign st_byte = {stat_q.mode, 4'h0, 1'b1, stat_q.hold_dis};
   assign mem_we  = step & (seq_q.phase == SSR_PH_DATA) & ~seq_q.is_read
                    & (seq_q.bitcnt == `SSR_DATA_LAST_BIT);

   // pointer advance per mode; reserved mode 11 behaves as byte mode
   // byte mode leaves the pointer alone, its frame ends after one byte
   always_comb
   begin
      case (stat_q.mode)
         `SSR_MODE_PAGE:
            next_addr = {seq_q.addr[`SSR_ADDR_W-1:`SSR_PAGE_LSB_W],
                         seq_q.addr[`SSR_PAGE_LSB_W-1:0] + 5'h01};
         `SSR_MODE_SEQ:
            next_addr = seq_q.addr + 13'h0001;
         default:
            next_addr = seq_q.addr;
      endcase
   end

   // next state of the sequence and of the status byte
   always_comb
   begin
      seq_d  = seq_q;
      stat_d = stat_q;
      if (step)
      begin
         seq_d.shreg  = {seq_q.shreg[14:0], si};
         seq_d.bitcnt = seq_q.bitcnt + 5'h01;
         case (seq_q.phase)
            SSR_PH_CMD:
            begin
               if (seq_q.bitcnt == `SSR_CMD_LAST_BIT)
               begin
                  seq_d.bitcnt  = 5'h00;
                  seq_d.is_read = (in_byte == `SSR_OP_MEM_READ);
                  case (in_byte)
                     `SSR_OP_MEM_READ,
                     `SSR_OP_MEM_WRITE:    seq_d.phase = SSR_PH_ADDR;
                     `SSR_OP_STATUS_READ:  seq_d.phase = SSR_PH_ST_RD;
                     `SSR_OP_STATUS_WRITE: seq_d.phase = SSR_PH_ST_WR;
                     default:              seq_d.phase = SSR_PH_IDLE;
                  endcase
               end
            end
            SSR_PH_ADDR:
            begin
               if (seq_q.bitcnt == `SSR_ADDR_LAST_BIT)
               begin
                  // top three address bits are don't care
                  seq_d.addr   = {seq_q.shreg[11:0], si};
                  seq_d.bitcnt = 5'h00;
                  seq_d.phase  = SSR_PH_DATA;
               end
            end
            SSR_PH_DATA:
            begin
               if (seq_q.bitcnt == `SSR_DATA_LAST_BIT)
               begin
                  seq_d.bitcnt = 5'h00;
                  seq_d.addr   = next_addr;
                  // byte mode moves exactly one data byte
                  if (stat_q.mode != `SSR_MODE_PAGE && stat_q.mode != `SSR_MODE_SEQ)
                     seq_d.phase = SSR_PH_IDLE;
               end
            end
            SSR_PH_ST_RD:
            begin
               // status byte repeats while the master keeps clocking
               if (seq_q.bitcnt == `SSR_DATA_LAST_BIT)
                  seq_d.bitcnt = 5'h00;
            end
            SSR_PH_ST_WR:
            begin
               // only the mode and pause bits are kept; the rest read back fixed
               if (seq_q.bitcnt == `SSR_DATA_LAST_BIT)
               begin
                  stat_d.mode     = in_byte[`SSR_ST_MODE_HI:`SSR_ST_MODE_LO];
                  stat_d.hold_dis = in_byte[`SSR_ST_HOLD_DIS_BIT];
                  seq_d.phase     = SSR_PH_IDLE;
               end
            end
            default:
            begin
               seq_d.bitcnt = seq_q.bitcnt;
            end
         endcase
      end
   end

   // sequence registers; cleared by chip select high
   // the clear is clean because chip select moves only while the clock is low
   always_ff @(posedge sck or posedge seq_clr)
   begin
      if (seq_clr)
         seq_q <= '{phase: SSR_PH_CMD, bitcnt: 5'h00, shreg: 16'h0000,
                    is_read: 1'b0, addr: 13'h0000};
      else
         seq_q <= seq_d;
   end

   // status byte keeps its value across frames
   always_ff @(posedge sck or posedge rst)
   begin
      if (rst)
         stat_q <= '{mode: `SSR_MODE_RESET, hold_dis: `SSR_HOLD_DIS_RESET};
      else
         stat_q <= stat_d;
   end

   // array write on the eighth bit only, so a cut byte never lands
   // the array has no reset; unwritten bytes read as unknown
   always_ff @(posedge sck)
   begin
      if (mem_we)
         mem[seq_q.addr] <= in_byte;
   end

   // ---------------------------------------------------------------
   // serial output, falling serial clock
   // ---------------------------------------------------------------
   // the bit shown is picked by the bit counter, msb first
   // while paused the flop holds, so the bit resumes where it stood
   always_comb
   begin
      out_d = out_q;
      if (~cs_n & ~paused)
      begin
         case (seq_q.phase)
            SSR_PH_DATA:
            begin
               out_d.so    = rd_byte[~seq_q.bitcnt[2:0]];
               out_d.so_oe = seq_q.is_read;
            end
            SSR_PH_ST_RD:
            begin
               out_d.so    = st_byte[~seq_q.bitcnt[2:0]];
               out_d.so_oe = 1'b1;
            end
            default:
            begin
               out_d.so    = 1'b0;
               out_d.so_oe = 1'b0;
            end
         endcase
      end
   end

   // falling edge update gives the master half a period of settled data
   always_ff @(negedge sck or posedge out_clr)
   begin
      if (out_clr)
         out_q <= '{so: 1'b0, so_oe: 1'b0};
      else
         out_q <= out_d;
   end

   // pause must float the pin at once and restore it without a clock edge
   assign so    = out_q.so;
   assign so_oe = out_q.so_oe & ~paused;

   // ---------------------------------------------------------------
   // system clock mirror
   // ---------------------------------------------------------------
   // two-stage level sync; status bits change only between frames, so
   // a one-cycle tear between the three bits is the accepted limitation
   always_comb
   begin
      sys_d.meta = {stat_q.mode, stat_q.hold_dis, ~cs_n};
      sys_d.sync = sys_q.meta;
   end

   // mirror stages; reset shows byte mode and no selection
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         sys_q <= '{meta: 4'h0, sync: 4'h0};
      else
         sys_q <= sys_d;
   end

   // system side outputs straight from the second stage
   assign sys_mode     = sys_q.sync[3:2];
   assign sys_hold_dis = sys_q.sync[1];
   assign sys_selected = sys_q.sync[0];

endmodule // ssr_sram
